// ===== hw/tas_defines.vh
// Constants for the tamp apply sequencer
`ifndef TAS_DEFINES_VH
`define TAS_DEFINES_VH
// ==========================================================
// Register map (byte addresses)
`define TAS_OFF_CTRL      8'h00
`define TAS_OFF_STAT      8'h04
`define TAS_OFF_ERR       8'h08
// ==========================================================
// Control field positions and reset value
`define TAS_CTRL_TWO_STEP 0
`define TAS_CTRL_STOP     1
`define TAS_CTRL_START_EN 2
`define TAS_CTRL_RESET    3'h4
// ==========================================================
// Error field positions
`define TAS_ERR_UP        0
`define TAS_ERR_DOWN      1
`define TAS_ERR_VAC_BLK   2
`define TAS_ERR_NO_LABEL  3
// ==========================================================
// Timing, clock in kHz and times in ms
`define TAS_CLK_KHZ       20000
`define TAS_TRAVEL_MS     3000
`define TAS_VTEST_MS      200
`define TAS_BLINK_MS      250
`define TAS_FAST_MS       62
// Same times as cycle counts of the 20 MHz clock
`define TAS_TRAVEL_CYC    26'd60000000
`define TAS_VTEST_CYC     26'd4000000
`define TAS_BLINK_CYC     26'd5000000
`define TAS_FAST_CYC      26'd1240000
`endif

// ===== hw/tas_sequencer.v
// Tamp apply sequencer with its APB register slave
// What this block does
// - Start with a job pending picks the label and applies it directly, or holds it for a second press in two-step mode.
// - Pad down with pressure reached stops downward drive and returns up.
// - Cycle ends only when pad is up; then next start is taken.
// - Start lamp follows the incoming start signal.
// - Up lamp follows up sensor, flashes on up error.
// - Up sensor lost while label feeds raises up error.
// - Pad not back up within 3 s after apply raises up error.
// - Down lamp follows down sensor, flashes on down error.
// - Pad not down within 3 s after apply starts raises down error.
// - Errors stay latched until reset button, external stop or control register stop.
// - Vacuum lamp lit while vacuum sensor reports label on pad.
// - Every reset runs vacuum test; blocked path raises fast-flash error.
// - Label-not-on-pad error lights error lamp, vacuum lamp slow flash.
// - Error lamp steady during applicator error; other lamp names it.
// - Printer error flashes error lamp; its clearing resets the device.
// - Two-step lamp lit while two-step mode is active.
// - Suction on at print start, off at down, error, removal, stop.
// - Cylinder on once label is on pad (in two-step mode only after the second press), off at down, error, stop.
// - Beacon on for any applicator or printer error until cleared.
// - Reset held halts all motion; release reinitializes with vacuum test.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "tas_defines.vh"

module tas_sequencer #(
  // Cycle counts at the 20 MHz clock; a bench may shrink them
  parameter [25:0] TRAVEL_CYC = `TAS_TRAVEL_CYC,
  parameter [25:0] VTEST_CYC  = `TAS_VTEST_CYC,
  parameter [25:0] BLINK_CYC  = `TAS_BLINK_CYC,
  parameter [25:0] FAST_CYC   = `TAS_FAST_CYC
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Trigger port and printer
  input  wire        start_in,
  input  wire        ext_stop,
  input  wire        job_pending,
  input  wire        print_busy,
  input  wire        label_feeding,
  input  wire        printer_err,
  // Buttons
  input  wire        reset_btn,
  input  wire        mode_btn,
  // Sensors
  input  wire        up_sens,
  input  wire        down_sens,
  input  wire        vac_sens,
  input  wire        pressure_ok,
  // Valves
  output reg         suction_valve,
  output reg         cylinder_valve,
  // Lamps and beacon
  output reg         lamp_start,
  output reg         lamp_up,
  output reg         lamp_down,
  output reg         lamp_vac,
  output reg         lamp_err,
  output reg         lamp_two_step,
  output reg         beacon
);

  // ==========================================================
  // States, one-hot
  localparam [7:0] S_HALT  = 8'h01;
  localparam [7:0] S_VTEST = 8'h02;
  localparam [7:0] S_IDLE  = 8'h04;
  localparam [7:0] S_FEED  = 8'h08;
  localparam [7:0] S_HOLD  = 8'h10;
  localparam [7:0] S_DOWN  = 8'h20;
  localparam [7:0] S_RET   = 8'h40;
  localparam [7:0] S_ERR   = 8'h80;

  // Address match used by read and write paths
  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  reg  [7:0]  state;
  reg  [7:0]  next_state;
  reg  [25:0] timer;
  reg  [25:0] blink_cnt;
  reg  [25:0] fast_cnt;
  reg         blink;
  reg         fast;
  reg  [3:0]  err;
  reg  [3:0]  next_err;
  reg         two_step;
  reg         start_en;
  reg         start_q;
  reg         mode_q;
  reg         feed_q;
  reg         prn_err_q;
  reg         soft_stop;
  reg         fed;
  wire        start_rise;
  wire        mode_rise;
  wire        feed_fall;
  wire        stop_req;
  wire        app_err;
  wire        wr;
  wire        rd_ok;

  // ==========================================================
  // APB access, zero wait states
  assign pready  = 1'b1;
  assign wr      = psel & penable & pwrite;
  assign rd_ok   = hit(paddr, `TAS_OFF_CTRL) | hit(paddr, `TAS_OFF_STAT) |
                   hit(paddr, `TAS_OFF_ERR);
  assign pslverr = psel & penable & ~rd_ok;

  // Read data registered in setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      if (hit(paddr, `TAS_OFF_CTRL))
        prdata <= {29'h0, start_en, 1'b0, two_step};
      else if (hit(paddr, `TAS_OFF_STAT))
        prdata <= {16'h0, state, up_sens, down_sens, vac_sens, pressure_ok,
                   printer_err, job_pending, suction_valve, cylinder_valve};
      else if (hit(paddr, `TAS_OFF_ERR))
        prdata <= {28'h0, err};
      // Unmapped addresses read as zero
      else
        prdata <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Edge detection on trigger inputs
  assign start_rise = start_in & ~start_q;
  assign mode_rise  = mode_btn & ~mode_q;
  assign feed_fall  = ~label_feeding & feed_q;
  assign stop_req   = reset_btn | ext_stop | soft_stop;
  assign app_err    = |err;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q   <= 1'b0;
      mode_q    <= 1'b0;
      feed_q    <= 1'b0;
      prn_err_q <= 1'b0;
    end else begin
      start_q   <= start_in;
      mode_q    <= mode_btn;
      feed_q    <= label_feeding;
      prn_err_q <= printer_err;
    end
  end

  // ==========================================================
  // Blink generators, slow and rapid
  // Free running so lamps flashing at the same rate share one phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt <= 26'h000_0000;
      fast_cnt  <= 26'h000_0000;
      blink     <= 1'b0;
      fast      <= 1'b0;
    end else begin
      if (blink_cnt >= BLINK_CYC - 26'h1) begin
        blink_cnt <= 26'h000_0000;
        blink     <= ~blink;
      end else begin
        blink_cnt <= blink_cnt + 26'h1;
      end
      if (fast_cnt >= FAST_CYC - 26'h1) begin
        fast_cnt <= 26'h000_0000;
        fast     <= ~fast;
      end else begin
        fast_cnt <= fast_cnt + 26'h1;
      end
    end
  end

  // ==========================================================
  // Control register: mode, soft stop, start enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      two_step  <= 1'b0;
      start_en  <= 1'b1;
      soft_stop <= 1'b0;
    end else begin
      soft_stop <= wr & hit(paddr, `TAS_OFF_CTRL) & pwdata[`TAS_CTRL_STOP];
      if (wr & hit(paddr, `TAS_OFF_CTRL)) begin
        start_en <= pwdata[`TAS_CTRL_START_EN];
      end
      // Press enters two-step; mode ends with the cycle or a stop
      if (mode_rise & (state == S_IDLE)) begin
        two_step <= 1'b1;
      end else if (wr & hit(paddr, `TAS_OFF_CTRL)) begin
        two_step <= pwdata[`TAS_CTRL_TWO_STEP];
      end else if (stop_req | (state == S_RET & up_sens)) begin
        two_step <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Next state and error latching
  always @* begin
    next_state = state;
    next_err   = err;
    case (state)
      S_HALT: begin
        // Stay stopped while held, test vacuum on release
        if (!stop_req && !printer_err)
          next_state = S_VTEST;
      end
      S_VTEST: begin
        // Suction runs for the test; a closed path reads as blocked
        if (timer >= VTEST_CYC - 26'h1) begin
          if (vac_sens) begin
            next_err[`TAS_ERR_VAC_BLK] = 1'b1;
            next_state = S_ERR;
          end else begin
            next_state = S_IDLE;
          end
        end
      end
      S_IDLE: begin
        // Only new starts with a job and no latched error
        // A held start must fall and rise again before it counts
        if (start_rise & job_pending & start_en & ~app_err)
          next_state = S_FEED;
      end
      S_FEED: begin
        if (label_feeding & ~up_sens) begin
          next_err[`TAS_ERR_UP] = 1'b1;
          next_state = S_ERR;
        end else if (fed & feed_fall) begin
          if (!vac_sens) begin
            next_err[`TAS_ERR_NO_LABEL] = 1'b1;
            next_state = S_ERR;
          end else if (two_step) begin
            next_state = S_HOLD;
          end else begin
            next_state = S_DOWN;
          end
        end
      end
      S_HOLD: begin
        // Label waits on pad for the second press
        if (!vac_sens)
          next_state = S_IDLE;
        else if (mode_rise)
          next_state = S_DOWN;
      end
      S_DOWN: begin
        if (down_sens & pressure_ok) begin
          next_state = S_RET;
        end else if (timer >= TRAVEL_CYC - 26'h1) begin
          next_err[`TAS_ERR_DOWN] = 1'b1;
          next_state = S_ERR;
        end
      end
      S_RET: begin
        if (up_sens) begin
          next_state = S_IDLE;
        end else if (timer >= TRAVEL_CYC - 26'h1) begin
          next_err[`TAS_ERR_UP] = 1'b1;
          next_state = S_ERR;
        end
      end
      S_ERR: begin
        // Parked with valves off until a stop clears the latch or a printer fault forces halt
        next_state = S_ERR;
      end
      default: begin
        next_state = S_HALT;
      end
    endcase
    // Stop or printer fault overrides every state
    if (stop_req | printer_err) begin
      next_state = S_HALT;
    end
    // Only a button, external stop or control register stop clears latched errors
    if (stop_req) begin
      next_err = 4'h0;
    end
  end

  // ==========================================================
  // State, travel timer and feed tracker
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_VTEST;
      err   <= 4'h0;
      timer <= 26'h000_0000;
      fed   <= 1'b0;
    end else begin
      state <= next_state;
      err   <= next_err;
      // Timer restarts on each state change
      // Saturates so a long wait cannot wrap into a false timeout
      if (next_state != state)
        timer <= 26'h000_0000;
      else if (timer != 26'h3ff_ffff)
        timer <= timer + 26'h1;
      // Feed seen once within this cycle
      if (state != S_FEED)
        fed <= 1'b0;
      else if (label_feeding)
        fed <= 1'b1;
    end
  end

  // ==========================================================
  // Valve drive
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suction_valve  <= 1'b0;
      cylinder_valve <= 1'b0;
    end else begin
      // Suction on from print start until down, error, removal, stop
      case (next_state)
        S_VTEST: suction_valve <= 1'b1;
        S_FEED:  suction_valve <= suction_valve | print_busy;
        S_HOLD:  suction_valve <= 1'b1;
        S_DOWN:  suction_valve <= ~down_sens;
        default: suction_valve <= 1'b0;
      endcase
      // Cylinder on while applying only
      // Follows the next state so it drops together with an error
      cylinder_valve <= (next_state == S_DOWN);
    end
  end

  // ==========================================================
  // Lamps and beacon
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_start    <= 1'b0;
      lamp_up       <= 1'b0;
      lamp_down     <= 1'b0;
      lamp_vac      <= 1'b0;
      lamp_err      <= 1'b0;
      lamp_two_step <= 1'b0;
      beacon        <= 1'b0;
    end else begin
      // Lamps lag their inputs by one clock
      lamp_start    <= start_in;
      lamp_up       <= err[`TAS_ERR_UP] ? blink : up_sens;
      lamp_down     <= err[`TAS_ERR_DOWN] ? blink : down_sens;
      if (err[`TAS_ERR_VAC_BLK])
        lamp_vac <= fast;
      else if (err[`TAS_ERR_NO_LABEL])
        lamp_vac <= blink;
      else
        lamp_vac <= vac_sens;
      // Steady for applicator errors, flashing for printer errors
      lamp_err      <= app_err | (printer_err & blink);
      lamp_two_step <= two_step;
      beacon        <= app_err | printer_err;
    end
  end

endmodule // tas_sequencer

// ===== verif/tamp_apply_sequencer_test.sv
// Self-checking testbench for the tamp apply sequencer
`timescale 1ns/1ps
module tamp_apply_sequencer_test;
  // ==========================================================
  // Signals
  logic pclk, presetn, psel, penable, pwrite, start_in, ext_stop, job, printer_err;
  logic reset_btn, mode_btn, up_sens, down_sens, vac_sens, pressure_ok;
  logic [2:0]  lo, hi;
  logic [7:0]  paddr;
  logic [31:0] pwdata, seed;
  logic [32:0] qe[$], qm[$];
  wire  [31:0] prdata;
  wire pready, pslverr, job_pending, print_busy, label_feeding, suction_valve, cylinder_valve;
  wire lamp_start, lamp_up, lamp_down, lamp_vac, lamp_err, lamp_two_step, beacon;
  int err_total, checks_done, i;
  tas_sequencer #(.TRAVEL_CYC(26'd50), .VTEST_CYC(26'd8), .BLINK_CYC(26'd4),
    .FAST_CYC(26'd2)) tas_sequencer_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .start_in, .ext_stop, .job_pending,
    .print_busy, .label_feeding, .printer_err, .reset_btn, .mode_btn, .up_sens, .down_sens,
    .vac_sens, .pressure_ok, .suction_valve, .cylinder_valve, .lamp_start, .lamp_up,
    .lamp_down, .lamp_vac, .lamp_err, .lamp_two_step, .beacon);
  tas_printer_model tas_printer_model_inst (.pclk, .presetn, .job, .start_in,
    .lag(seed[1:0]), .job_pending, .print_busy, .label_feeding);
  // ==========================================================
  // Tasks
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    qe.push_back(e);
    qm.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  // Runs a cycle up to the point where the cylinder should drive down
  task automatic cycle_start(input logic two);
    job <= 1'b1;
    tick(2);
    start_in <= 1'b1;
    for (i = 0; i < 30 && label_feeding !== 1'b1; i++) @(posedge pclk);
    vac_sens <= 1'b1;
    for (i = 0; i < 30 && label_feeding !== 1'b0; i++) @(posedge pclk);
    tick(3);
    chk(suction_valve, 1);
    chk(cylinder_valve, !two);
    up_sens <= 1'b0;
  endtask
  // Samples the error, down and vacuum lamps for both levels
  task automatic watch;
    {lo, hi} = '0;
    repeat (12) begin
      @(posedge pclk);
      hi |= {lamp_err, lamp_down, lamp_vac};
      lo |= ~{lamp_err, lamp_down, lamp_vac};
    end
  endtask
  task automatic final_report;
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Read monitor compares against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && qe.size() > 0)
      chk({pslverr, prdata} & qm.pop_front(), qe.pop_front());
  // Clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    tick(3000);
    err_total++;
    final_report;
  end
  // ==========================================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, start_in, ext_stop, job, printer_err} = '0;
    {reset_btn, mode_btn, down_sens, vac_sens, pressure_ok} = '0;
    up_sens = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'h64eb561e;
    err_total = 0;
    checks_done = 0;
    tick(16);
    presetn <= 1'b1;
    tick(12);
    rd(8'h00, 33'h4, '1);
    rd(8'h04, 33'h0400, 33'hff00);
    seed = xs(seed);
    apb(1'b1, 8'h0c, seed);
    rd(8'h0c, 33'h1_0000_0000, '1);
    rd(8'h00, 33'h4, '1);
    tick(seed[2:0] + 1);
    cycle_start(1'b0);
    chk(lamp_start, 1);
    tick(2);
    down_sens <= 1'b1;
    pressure_ok <= 1'b1;
    tick(3);
    chk({cylinder_valve, suction_valve}, 0);
    {start_in, down_sens, pressure_ok, vac_sens} <= '0;
    tick(2);
    up_sens <= 1'b1;
    tick(3);
    chk(lamp_start, 0);
    rd(8'h04, 33'h0400, 33'hff00);
    seed = xs(seed);
    cycle_start(1'b0);
    tick(60);
    rd(8'h08, 33'h2, '1);
    chk({lamp_err, beacon, cylinder_valve}, 3'b110);
    watch;
    chk({lo[1], hi[1]}, 2'b11);
    start_in <= 1'b0;
    tick(2);
    start_in <= 1'b1;
    tick(3);
    rd(8'h04, 33'h8000, 33'hff00);
    {job, vac_sens, start_in} <= '0;
    up_sens <= 1'b1;
    ext_stop <= 1'b1;
    tick(1);
    ext_stop <= 1'b0;
    tick(14);
    rd(8'h08, 33'h0, '1);
    chk(beacon, 0);
    vac_sens <= 1'b1;
    reset_btn <= 1'b1;
    tick(3);
    chk(suction_valve, 0);
    reset_btn <= 1'b0;
    tick(14);
    rd(8'h08, 33'h4, '1);
    chk(lamp_err, 1);
    watch;
    chk({lo[0], hi[0]}, 2'b11);
    vac_sens <= 1'b0;
    reset_btn <= 1'b1;
    tick(2);
    reset_btn <= 1'b0;
    tick(14);
    rd(8'h08, 33'h0, '1);
    printer_err <= 1'b1;
    tick(2);
    watch;
    chk({lo[2], hi[2], beacon}, 3'b111);
    printer_err <= 1'b0;
    tick(14);
    rd(8'h04, 33'h0400, 33'hff00);
    mode_btn <= 1'b1;
    tick(2);
    mode_btn <= 1'b0;
    tick(2);
    chk(lamp_two_step, 1);
    cycle_start(1'b1);
    mode_btn <= 1'b1;
    tick(2);
    mode_btn <= 1'b0;
    tick(2);
    chk(cylinder_valve, 1);
    final_report;
  end
endmodule // tamp_apply_sequencer_test

// ===== verif/tas_printer_model.sv
// Printer side model that prints and feeds one label per start edge
`timescale 1ns/1ps
module tas_printer_model (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Bench controls
  input  wire       job,
  input  wire       start_in,
  input  wire [1:0] lag,
  // Printer status
  output reg        job_pending,
  output reg        print_busy,
  output reg        label_feeding
);
  reg       start_q;
  reg [4:0] cnt;
  // Lag sets how slowly the printer answers a start
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
      cnt <= 5'h00;
      job_pending <= 1'b0;
      print_busy <= 1'b0;
      label_feeding <= 1'b0;
    end else begin
      start_q <= start_in;
      job_pending <= job;
      if (cnt == 5'h10)
        cnt <= 5'h00;
      else if (cnt != 5'h00)
        cnt <= cnt + 5'h01;
      else if (start_in && !start_q && job_pending)
        cnt <= 5'h01;
      print_busy <= (cnt > {3'h0, lag}) && (cnt < 5'h0c);
      label_feeding <= (cnt > {3'h0, lag} + 5'h04) && (cnt < 5'h0c);
    end
  end
endmodule // tas_printer_model

// ===== verif/tas_sequencer_sva.sv
// Pin level assertions for the tamp apply sequencer
`timescale 1ns/1ps
module tas_seq_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Inputs
  input wire logic start_in,
  input wire logic reset_btn,
  input wire logic up_sens,
  input wire logic down_sens,
  input wire logic vac_sens,
  input wire logic pressure_ok,
  // Outputs
  input wire logic suction_valve,
  input wire logic cylinder_valve,
  input wire logic lamp_start,
  input wire logic lamp_up,
  input wire logic lamp_down,
  input wire logic lamp_vac,
  input wire logic lamp_err,
  input wire logic lamp_two_step,
  input wire logic beacon
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_start_lamp: assert property (
    $past(presetn) |-> lamp_start == $past(start_in)) else $error("start lamp wrong");
  chk_up_lamp: assert property (
    $past(presetn) && !lamp_err && !$past(lamp_err) |-> lamp_up == $past(up_sens))
    else $error("up lamp wrong");
  chk_down_lamp: assert property (
    $past(presetn) && !lamp_err && !$past(lamp_err) |-> lamp_down == $past(down_sens))
    else $error("down lamp wrong");
  chk_vac_lamp: assert property (
    $past(presetn) && !lamp_err && !$past(lamp_err) |-> lamp_vac == $past(vac_sens))
    else $error("vacuum lamp wrong");
  chk_err_beacon: assert property (
    lamp_err |-> beacon) else $error("beacon missing with error lamp");
  chk_err_valves: assert property (
    beacon && $past(beacon) |-> !cylinder_valve && !suction_valve)
    else $error("valve on during error");
  chk_reset_halt: assert property (
    $past(presetn) && $past(reset_btn) && $past(reset_btn, 2) |-> !cylinder_valve && !suction_valve)
    else $error("motion while reset held");
  chk_tamp_return: assert property (
    cylinder_valve && down_sens && pressure_ok |-> ##[1:3] !cylinder_valve)
    else $error("cylinder kept on at down");
  chk_vac_test: assert property (
    $fell(reset_btn) |-> ##[1:3] suction_valve) else $error("no vacuum test");
  // Main scenarios reached
  cover property ($rose(cylinder_valve));
  cover property ($rose(beacon));
  cover property ($rose(lamp_two_step));
endmodule // tas_seq_chk

bind tas_sequencer tas_seq_chk tas_seq_chk_inst (.pclk, .presetn, .start_in, .reset_btn,
  .up_sens, .down_sens, .vac_sens, .pressure_ok, .suction_valve, .cylinder_valve,
  .lamp_start, .lamp_up, .lamp_down, .lamp_vac, .lamp_err, .lamp_two_step, .beacon);
